// [design/burst_defs.svh]
// burst_defs.svh: widths and timing counts shared by both link ends
// assumes a 250 MHz system clock common to both ends
`ifndef BURST_DEFS_SVH
`define BURST_DEFS_SVH
`define CLK_NS 4
`define CK_HALF 4
`define CK_NS (2 * `CK_HALF * `CLK_NS)
`define CAS_LAT 3
`define T_WR_NS 15
`define WR_LC ((`T_WR_NS + `CK_NS - 1) / `CK_NS)
`define WTR_LC 1
`define T_RAS_NS 40
`define RAS_LC ((`T_RAS_NS + `CK_NS - 1) / `CK_NS)
`define BA_W 2
`define ROW_W 2
`define COL_W 4
`define DQ_W 32
`define LANES 4
`define WR_DQS_ON 8
`define WR_D0 10
`define WR_E0 12
`endif

// [design/burst_pkg.sv]
// burst_pkg: types shared by the controller end and the memory end
// assumes burst_defs.svh is on the include path
`include "burst_defs.svh"
package burst_pkg;
  typedef enum logic [2:0] {CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_BST, CMD_PRE} cmd_e;
  // burst length code: 2 << code elements
  typedef logic [1:0] bl_t;
  typedef logic [`ROW_W+`COL_W-1:0] radr_t;
  typedef struct packed {
    logic v;
    logic stop;
    logic pre;
    logic all;
    logic [`BA_W-1:0] ba;
    radr_t adr;
  } rq_s;

  function automatic logic [4:0] bl_elems(input bl_t code);
    return 5'(5'h2 << code);
  endfunction : bl_elems
endpackage : burst_pkg

// [design/lpddr_link_if.sv]
// lpddr_link_if: command pins and shared data pins between the two ends
// assumes both ends run on the same system clock; wires resolve by OR of enables
`timescale 1ns/1ps
`include "burst_defs.svh"
interface lpddr_link_if
  import burst_pkg::*;
();
  logic ck;
  cmd_e cmd;
  logic [`BA_W-1:0] ba;
  logic [`COL_W-1:0] addr;
  logic ap;
  logic [`DQ_W-1:0] dq_c;
  logic dq_c_oe;
  logic [`LANES-1:0] dqs_c;
  logic dqs_c_oe;
  logic [`LANES-1:0] dm;
  logic [`DQ_W-1:0] dq_d;
  logic dq_d_oe;
  logic [`LANES-1:0] dqs_d;
  logic dqs_d_oe;
  logic [`DQ_W-1:0] dq;
  logic [`LANES-1:0] dqs;

  assign dq = (dq_c & {`DQ_W{dq_c_oe}}) | (dq_d & {`DQ_W{dq_d_oe}});
  assign dqs = (dqs_c & {`LANES{dqs_c_oe}}) | (dqs_d & {`LANES{dqs_d_oe}});

  modport ctrl (output ck, cmd, ba, addr, ap, dq_c, dq_c_oe, dqs_c, dqs_c_oe, dm,
                input dq, dqs);
  modport mem (input ck, cmd, ba, addr, ap, dm, dq, dqs,
               output dq_d, dq_d_oe, dqs_d, dqs_d_oe);
endinterface : lpddr_link_if

// [design/lpddr_ctrl_end.sv]
// lpddr_ctrl_end: controller end; makes the link clock, issues commands, moves data
// assumes the memory end shares CLK_I; user requests are offered once per link cycle
`timescale 1ns/1ps
`include "burst_defs.svh"
module lpddr_ctrl_end
  import burst_pkg::*;
(
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // configuration
  input wire bl_t BL_I,
  // command requests
  input wire logic REQ_VALID_I,
  input wire cmd_e REQ_CMD_I,
  input wire logic [`BA_W-1:0] REQ_BA_I,
  input wire logic [`COL_W-1:0] REQ_ADDR_I,
  input wire logic REQ_AP_I,
  output logic REQ_READY_O,
  // write data
  input wire logic [`DQ_W-1:0] WD_I,
  input wire logic [`LANES-1:0] WM_I,
  output logic WD_TAKE_O,
  // read data
  output logic [`DQ_W-1:0] RD_DATA_O,
  output logic RD_VALID_O,
  // link
  lpddr_link_if.ctrl LNK
);
  logic [2:0] ph_r;
  logic [3:0] open_r;
  logic [4:0] rd_left_r;
  logic [2:0] wtr_r;
  logic [2:0] wr_r;
  logic w_act_r;
  logic [6:0] w_t_r;
  logic [4:0] w_n_r;
  logic dqs_r;
  logic [`DQ_W-1:0] dq_r;
  logic [`LANES-1:0] dm_r;
  logic legal;
  logic need_bst;
  logic ins_bst;
  logic issue;
  logic slot;
  logic [4:0] bl_n;
  logic [6:0] w_end;
  logic d_phase;
  logic e_phase;
  logic s_m;
  logic s_q;
  logic s_d;
  logic [`DQ_W-1:0] d_m;
  logic [`DQ_W-1:0] d_q;

  assign bl_n = bl_elems(BL_I);
  // commands launch one system cycle after the falling link edge so they are stable at the rise
  assign slot = ph_r == 3'h4;
  assign need_bst = (rd_left_r > 5'(`CAS_LAT)) && (BL_I != 2'h0);

  always_comb
  begin
    unique case (REQ_CMD_I)
      CMD_RD: legal = open_r[REQ_BA_I] && !w_act_r && wtr_r == 3'h0;
      CMD_WR: legal = open_r[REQ_BA_I] && rd_left_r == 5'h0 && !w_act_r;
      CMD_PRE: legal = !w_act_r && wr_r == 3'h0;
      CMD_ACT: legal = !open_r[REQ_BA_I];
      default: legal = 1'b1;
    endcase
  end

  assign REQ_READY_O = slot && legal;
  assign issue = REQ_VALID_I && REQ_READY_O;
  // a write behind an unfinished read burst longer than two first spends its slot on a terminate
  assign ins_bst = slot && REQ_VALID_I && REQ_CMD_I == CMD_WR && need_bst;

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      ph_r <= 3'h0;
    else
      ph_r <= ph_r + 3'h1;
  end

  assign LNK.ck = ~ph_r[2];

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      LNK.cmd <= CMD_NOP;
      LNK.ba <= '0;
      LNK.addr <= '0;
      LNK.ap <= 1'b0;
    end
    else if (slot)
    begin
      LNK.cmd <= issue ? REQ_CMD_I : (ins_bst ? CMD_BST : CMD_NOP);
      LNK.ba <= REQ_BA_I;
      LNK.addr <= REQ_ADDR_I;
      LNK.ap <= issue && REQ_AP_I;
    end
  end

  // open rows per bank and pending burst counts shared by all banks
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      open_r <= 4'h0;
      rd_left_r <= 5'h0;
      wtr_r <= 3'h0;
      wr_r <= 3'h0;
    end
    else
    begin
      if (issue && REQ_CMD_I == CMD_ACT)
        open_r[REQ_BA_I] <= 1'b1;
      else if (issue && REQ_CMD_I == CMD_PRE)
        open_r <= REQ_AP_I ? 4'h0 : (open_r & ~(4'h1 << REQ_BA_I));
      else if (issue && REQ_AP_I && (REQ_CMD_I == CMD_RD || REQ_CMD_I == CMD_WR))
        open_r[REQ_BA_I] <= 1'b0;
      if (slot && issue && REQ_CMD_I == CMD_RD)
        rd_left_r <= 5'(bl_n >> 1) + 5'(`CAS_LAT);
      else if (ins_bst)
        rd_left_r <= 5'(`CAS_LAT);
      else if (slot && rd_left_r != 5'h0)
        rd_left_r <= rd_left_r - 5'h1;
      if (w_act_r && w_t_r == w_end)
      begin
        wtr_r <= 3'(`WTR_LC + 1);
        wr_r <= 3'(`WR_LC + 1);
      end
      else if (slot)
      begin
        wtr_r <= (wtr_r != 3'h0) ? wtr_r - 3'h1 : 3'h0;
        wr_r <= (wr_r != 3'h0) ? wr_r - 3'h1 : 3'h0;
      end
    end
  end

  // write timing counted from the launch slot; a write waits out the one before,
  // since restarting the count mid-burst would cut the strobe and drop elements
  assign w_end = 7'(`WR_D0) + {w_n_r, 2'b00};
  assign d_phase = w_act_r && w_t_r >= 7'(`WR_D0) && w_t_r < w_end && w_t_r[1:0] == 2'b10;
  assign e_phase = w_act_r && w_t_r >= 7'(`WR_E0) && w_t_r < w_end + 7'h2
                   && w_t_r[1:0] == 2'b00;
  assign WD_TAKE_O = d_phase;

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      w_act_r <= 1'b0;
      w_t_r <= 7'h0;
      w_n_r <= 5'h0;
      dqs_r <= 1'b0;
      dq_r <= '0;
      dm_r <= '1;
    end
    else if (issue && REQ_CMD_I == CMD_WR)
    begin
      w_act_r <= 1'b1;
      w_t_r <= 7'h0;
      w_n_r <= bl_n;
    end
    else if (w_act_r)
    begin
      w_t_r <= w_t_r + 7'h1;
      if (w_t_r == w_end)
      begin
        w_act_r <= 1'b0;
        dqs_r <= 1'b0;
      end
      if (d_phase)
      begin
        dq_r <= WD_I;
        dm_r <= WM_I;
      end
      // first rise one and a quarter link periods after the command rise
      if (e_phase)
        dqs_r <= ~dqs_r;
    end
  end

  assign LNK.dq_c = dq_r;
  assign LNK.dm = dm_r;
  assign LNK.dq_c_oe = w_act_r && w_t_r > 7'(`WR_D0);
  assign LNK.dqs_c = {`LANES{dqs_r}};
  // strobe held low before the first rise and after the last element
  assign LNK.dqs_c_oe = w_act_r && w_t_r > 7'(`WR_DQS_ON);

  // read capture on any strobe edge while no write owns the bus
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      s_m <= 1'b0;
      s_q <= 1'b0;
      s_d <= 1'b0;
      d_m <= '0;
      d_q <= '0;
      RD_DATA_O <= '0;
      RD_VALID_O <= 1'b0;
    end
    else
    begin
      s_m <= LNK.dqs[0];
      s_q <= s_m;
      s_d <= s_q;
      d_m <= LNK.dq;
      d_q <= d_m;
      RD_VALID_O <= (s_q ^ s_d) && !w_act_r && wtr_r == 3'h0;
      if ((s_q ^ s_d) && !w_act_r)
        RD_DATA_O <= d_q;
    end
  end
endmodule : lpddr_ctrl_end

// [design/lpddr_mem_end.sv]
// lpddr_mem_end: memory end; takes commands on link rises, bursts data per byte lane
// assumes the controller keeps command legality; link pins pass two flops first
// Summary of operation
// - back-to-back reads concatenate at BL2, else interrupt
// - random reads cut bursts longer than two
// - reads accepted only to an open row
// - terminate stops read, row stays open
// - controller terminates read before issuing write; at BL2 it waits out the read instead
// - precharge two clocks after read yields two pairs
// - read auto precharge after BL/2 clocks
// - wide mode: four byte lanes, own strobes
// - narrow mode: low/high strobe per byte
// - write carries bank, column, auto precharge
// - mask low stores byte, high keeps it
// - first rising strobe, then every edge captures
// - controller holds strobe low around burst
// - first write strobe rise one clock later; the controller makes it one and a quarter clocks later
// - write ends after postamble plus recovery
// - idle after write: pins off, data ignored
// - new write restarts or extends burst
// - read after write waits write-to-read time
// - read truncating write drops later data
// - precharge after write waits recovery time
// - read data after CAS latency, then edges
// - terminate latency equals CAS latency
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "burst_defs.svh"
module lpddr_mem_end
  import burst_pkg::*;
(
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // static configuration
  input wire logic X16_I,
  input wire bl_t BL_I,
  // link
  lpddr_link_if.mem LNK
);
  localparam int AW = `BA_W + `ROW_W + `COL_W;

  logic ck_m;
  logic ck_q;
  logic ck_d;
  cmd_e cmd_m;
  cmd_e cmd_q;
  logic [`BA_W-1:0] ba_m;
  logic [`BA_W-1:0] ba_q;
  logic [`COL_W-1:0] addr_m;
  logic [`COL_W-1:0] addr_q;
  logic ap_m;
  logic ap_q;
  logic rise;
  logic fall;
  logic [4:0] bl_n;
  logic [3:0] open_v;
  logic [3:0] ras_ok;
  logic [`ROW_W-1:0] open_row [4];
  logic rd_take;
  logic wr_take;
  logic stop_in;
  rq_s pipe_r [`CAS_LAT];
  rq_s head;
  logic start;
  logic stop_now;
  logic rd_act_r;
  logic [4:0] rd_e_r;
  logic [`BA_W-1:0] rd_ba_r;
  radr_t rd_base_r;
  radr_t rd_src;
  logic [AW-1:0] rd_addr;
  logic [`DQ_W-1:0] rd_word;
  logic [`DQ_W-1:0] dq_o_r;
  logic dqs_o_r;
  logic oe_r;
  logic [`BA_W-1:0] wr_ba_r;
  radr_t wr_base_r;
  logic ap_pend_r;
  logic [`BA_W-1:0] ap_bank_r;
  logic [5:0] ap_cnt_r;
  logic ap_fire;
  logic [`LANES-1:0] lane_en;

  function automatic logic [`COL_W-1:0] burst_col(input logic [`COL_W-1:0] base,
                                                  input logic [4:0] idx,
                                                  input logic [4:0] n);
    logic [`COL_W-1:0] m;
    m = `COL_W'(n - 5'h1);
    return (base & ~m) | ((base + `COL_W'(idx)) & m);
  endfunction : burst_col

  assign bl_n = bl_elems(BL_I);

  // command pins sampled through the same two stages as the link clock
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      // link clock idles high in reset; a low reset value would fake a rise
      ck_m <= 1'b1;
      ck_q <= 1'b1;
      ck_d <= 1'b1;
      cmd_m <= CMD_NOP;
      cmd_q <= CMD_NOP;
      ba_m <= '0;
      ba_q <= '0;
      addr_m <= '0;
      addr_q <= '0;
      ap_m <= 1'b0;
      ap_q <= 1'b0;
    end
    else
    begin
      ck_m <= LNK.ck;
      ck_q <= ck_m;
      ck_d <= ck_q;
      cmd_m <= LNK.cmd;
      cmd_q <= cmd_m;
      ba_m <= LNK.ba;
      ba_q <= ba_m;
      addr_m <= LNK.addr;
      addr_q <= addr_m;
      ap_m <= LNK.ap;
      ap_q <= ap_m;
    end
  end

  assign rise = ck_q && !ck_d;
  assign fall = !ck_q && ck_d;
  assign rd_take = rise && cmd_q == CMD_RD && open_v[ba_q];
  assign wr_take = rise && cmd_q == CMD_WR && open_v[ba_q];
  assign stop_in = cmd_q == CMD_BST || cmd_q == CMD_PRE;

  // per-bank row state; an activation restarts the minimum active time
  for (genvar b = 0; b < 4; b++)
  begin : g_bank
    logic opn_r;
    logic [`ROW_W-1:0] row_r;
    logic [3:0] ras_r;
    logic hit;
    assign hit = ba_q == `BA_W'(b);
    always_ff @(posedge CLK_I)
    begin
      if (RST_I)
      begin
        opn_r <= 1'b0;
        row_r <= '0;
        ras_r <= 4'h0;
      end
      else if (rise)
      begin
        if (cmd_q == CMD_ACT && hit)
        begin
          opn_r <= 1'b1;
          row_r <= addr_q[`ROW_W-1:0];
          ras_r <= 4'(`RAS_LC);
        end
        else
        begin
          if (ras_r != 4'h0)
            ras_r <= ras_r - 4'h1;
          if ((cmd_q == CMD_PRE && (hit || ap_q)) || (ap_fire && ap_bank_r == `BA_W'(b)))
            opn_r <= 1'b0;
        end
      end
    end
    assign open_v[b] = opn_r;
    assign open_row[b] = row_r;
    assign ras_ok[b] = ras_r == 4'h0;
  end

  // auto precharge waits for its count and for the minimum active time
  assign ap_fire = rise && ap_pend_r && ap_cnt_r == 6'h0 && ras_ok[ap_bank_r];
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      ap_pend_r <= 1'b0;
      ap_bank_r <= '0;
      ap_cnt_r <= 6'h0;
    end
    else if ((rd_take || wr_take) && ap_q)
    begin
      ap_pend_r <= 1'b1;
      ap_bank_r <= ba_q;
      if (rd_take)
        ap_cnt_r <= 6'(bl_n >> 1) - 6'h1;
      else
        ap_cnt_r <= 6'(bl_n >> 1) + 6'(`WR_LC);
    end
    else if (ap_fire)
      ap_pend_r <= 1'b0;
    else if (rise && ap_cnt_r != 6'h0)
      ap_cnt_r <= ap_cnt_r - 6'h1;
  end

  // read and stop events wait CAS latency rises before they act
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      for (int i = 0; i < `CAS_LAT; i++)
        pipe_r[i] <= '0;
    end
    else if (rise)
    begin
      pipe_r[0] <= '{v: rd_take || stop_in, stop: !rd_take, pre: cmd_q == CMD_PRE,
                     all: ap_q, ba: ba_q, adr: {open_row[ba_q], addr_q}};
      for (int i = 1; i < `CAS_LAT; i++)
        pipe_r[i] <= pipe_r[i-1];
    end
  end

  assign head = pipe_r[`CAS_LAT-1];
  assign start = rise && head.v && !head.stop;
  // a single-bank precharge cuts only a burst in its own bank; a precharge of all banks cuts any burst
  assign stop_now = rise && head.v && head.stop
                    && (!head.pre || head.all || head.ba == rd_ba_r);

  assign rd_src = start ? head.adr : rd_base_r;
  assign rd_addr = {start ? head.ba : rd_ba_r, rd_src[`ROW_W+`COL_W-1:`COL_W],
                    burst_col(rd_src[`COL_W-1:0], start ? 5'h0 : rd_e_r, bl_n)};

  // a new read start wins over the end of the old burst
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      rd_act_r <= 1'b0;
      rd_e_r <= 5'h0;
      rd_ba_r <= '0;
      rd_base_r <= '0;
      dq_o_r <= '0;
      dqs_o_r <= 1'b0;
      oe_r <= 1'b0;
    end
    else if (start)
    begin
      rd_act_r <= 1'b1;
      rd_e_r <= 5'h1;
      rd_ba_r <= head.ba;
      rd_base_r <= head.adr;
      dq_o_r <= rd_word;
      dqs_o_r <= 1'b1;
      oe_r <= 1'b1;
    end
    else if (stop_now || ((rise || fall) && rd_act_r && rd_e_r == bl_n))
    begin
      rd_act_r <= 1'b0;
      dqs_o_r <= 1'b0;
      oe_r <= 1'b0;
    end
    else if ((rise || fall) && rd_act_r)
    begin
      rd_e_r <= rd_e_r + 5'h1;
      dq_o_r <= rd_word;
      dqs_o_r <= ~rd_e_r[0];
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      wr_ba_r <= '0;
      wr_base_r <= '0;
    end
    else if (wr_take)
    begin
      wr_ba_r <= ba_q;
      wr_base_r <= {open_row[ba_q], addr_q};
    end
  end

  // each byte lane keeps its own storage, strobe and element count
  for (genvar l = 0; l < `LANES; l++)
  begin : g_lane
    logic [7:0] mem_r [2**AW];
    logic s_m;
    logic s_q;
    logic s_d;
    logic [7:0] d_m;
    logic [7:0] d_q;
    logic k_m;
    logic k_q;
    logic arm_r;
    logic seen_r;
    logic [4:0] cnt_r;
    logic cap;
    assign lane_en[l] = !X16_I || l < 2;
    assign cap = arm_r && lane_en[l] && (s_q ^ s_d) && (seen_r || s_q);
    always_ff @(posedge CLK_I)
    begin
      if (RST_I)
      begin
        s_m <= 1'b0;
        s_q <= 1'b0;
        s_d <= 1'b0;
        d_m <= 8'h00;
        d_q <= 8'h00;
        k_m <= 1'b1;
        k_q <= 1'b1;
      end
      else
      begin
        s_m <= LNK.dqs[l];
        s_q <= s_m;
        s_d <= s_q;
        d_m <= LNK.dq[8*l +: 8];
        d_q <= d_m;
        k_m <= LNK.dm[l];
        k_q <= k_m;
      end
    end
    always_ff @(posedge CLK_I)
    begin
      if (RST_I)
      begin
        arm_r <= 1'b0;
        seen_r <= 1'b0;
        cnt_r <= 5'h0;
      end
      else if (wr_take)
      begin
        arm_r <= 1'b1;
        seen_r <= 1'b0;
        cnt_r <= 5'h0;
      end
      else if (rd_take)
        arm_r <= 1'b0;
      else if (cap)
      begin
        seen_r <= 1'b1;
        cnt_r <= cnt_r + 5'h1;
        if (cnt_r + 5'h1 == bl_n)
          arm_r <= 1'b0;
      end
    end
    always_ff @(posedge CLK_I)
    begin
      if (cap && !k_q)
        mem_r[{wr_ba_r, wr_base_r[`ROW_W+`COL_W-1:`COL_W],
               burst_col(wr_base_r[`COL_W-1:0], cnt_r, bl_n)}] <= d_q;
    end
    assign rd_word[8*l +: 8] = lane_en[l] ? mem_r[rd_addr] : 8'h00;
  end

  assign LNK.dq_d = dq_o_r;
  assign LNK.dq_d_oe = oe_r;
  assign LNK.dqs_d = {`LANES{dqs_o_r}} & lane_en;
  assign LNK.dqs_d_oe = oe_r;
endmodule : lpddr_mem_end

// [verif/lpddr_link_props.sv]
// lpddr_link_props: assertions on the link between the controller end and the memory end
// assumes one system clock for both ends and commands from the controller end only
`timescale 1ns/1ps
`include "burst_defs.svh"
module lpddr_link_props
  import burst_pkg::*;
(
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // link
  input wire logic ck,
  input wire cmd_e cmd,
  input wire logic dq_c_oe,
  input wire logic [`LANES-1:0] dqs_c,
  input wire logic dqs_c_oe,
  input wire logic dq_d_oe,
  input wire logic [`LANES-1:0] dqs_d,
  input wire logic dqs_d_oe,
  input wire logic [`LANES-1:0] dqs
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);

  a_ck_period: assert property ($rose(ck) |-> ck[*4] ##1 (!ck)[*4] ##1 ck)
    else $error("link clock period is not eight cycles");
  a_cmd_edge: assert property ($changed(cmd) |-> !ck && !$past(ck) && $past(ck, 2))
    else $error("command changed outside the cycle after the link clock fell");
  a_no_contention: assert property (!(dq_c_oe && dq_d_oe))
    else $error("both ends drive the data pins");
  a_wr_preamble: assert property ($rose(ck) && cmd == CMD_WR && !dqs_c_oe
    |-> ##1 (dqs == 4'h0)[*5] ##[1:5] (dqs_c_oe && dqs_c == 4'hF))
    else $error("write strobe preamble or first rise out of window");
  a_wr_postamble: assert property ($fell(dqs_c_oe) |-> $past(dqs_c) == 4'h0)
    else $error("write strobe released while high");
  a_rd_latency: assert property ($rose(ck) && cmd == CMD_RD && !dq_d_oe
    && $past(cmd, 8) != CMD_RD && $past(cmd, 16) != CMD_RD |-> ##[22:32] $rose(dq_d_oe))
    else $error("read data not after the cas latency");
  a_rd_strobe: assert property ($rose(dq_d_oe) |-> dqs_d_oe && dqs_d[1:0] == 2'h3)
    else $error("first read element without a high strobe");
  a_rd_toggle: assert property ($rose(dqs[0]) && dq_d_oe
    |-> (dqs[0] && dq_d_oe)[*4] ##1 !dqs[0])
    else $error("read element not a half link period");
  a_lane_pair: assert property (dqs_d_oe |-> dqs_d[0] == dqs_d[1])
    else $error("low and high byte strobes differ");
  a_bst_stop: assert property ($rose(ck) && cmd == CMD_BST && $past(cmd, 8) == CMD_RD
    |-> ##[22:32] $fell(dq_d_oe))
    else $error("terminate did not stop the read after the cas latency");
  a_pre_stop: assert property ($rose(ck) && cmd == CMD_PRE && $past(cmd, 16) == CMD_RD
    && $past(cmd, 8) == CMD_NOP |-> ##[22:32] $fell(dq_d_oe))
    else $error("precharge did not end the read after two pairs");
endmodule : lpddr_link_props

// [verif/tb.sv]
// tb: drives the controller end's user side, the memory end answers over the link
// assumes both ends share CLK_I; expected read data comes from a small memory image
`timescale 1ns/1ps
`include "burst_defs.svh"
module tb;
  import burst_pkg::*;
  logic CLK_I = 1'b0;
  logic RST_I = 1'b1;
  bl_t BL_I = 2'h3;
  logic X16_I = 1'b0;
  logic REQ_VALID_I = 1'b0;
  cmd_e REQ_CMD_I = CMD_NOP;
  logic [1:0] REQ_BA_I = 2'h0;
  logic [3:0] REQ_ADDR_I = 4'h0;
  logic REQ_AP_I = 1'b0;
  logic REQ_READY_O;
  logic WD_TAKE_O;
  logic RD_VALID_O;
  logic [31:0] RD_DATA_O;
  logic [31:0] wdat [64] = '{default: 32'h0};
  logic [3:0] wmsk [64] = '{default: 4'h0};
  logic [31:0] mexp [64];
  logic [31:0] rq [$];
  logic [31:0] eq [$];
  int wp = 0;
  int wd_idx = 0;
  int blen = 16;
  int fail_count = 0;
  int samples_checked = 0;

  always #2 CLK_I = ~CLK_I;

  lpddr_link_if lnk();
  lpddr_ctrl_end i_lpddr_ctrl_end (.CLK_I(CLK_I), .RST_I(RST_I), .BL_I(BL_I),
    .REQ_VALID_I(REQ_VALID_I), .REQ_CMD_I(REQ_CMD_I), .REQ_BA_I(REQ_BA_I),
    .REQ_ADDR_I(REQ_ADDR_I), .REQ_AP_I(REQ_AP_I), .REQ_READY_O(REQ_READY_O),
    .WD_I(wdat[wd_idx]), .WM_I(wmsk[wd_idx]), .WD_TAKE_O(WD_TAKE_O),
    .RD_DATA_O(RD_DATA_O), .RD_VALID_O(RD_VALID_O), .LNK(lnk));
  lpddr_mem_end i_lpddr_mem_end (.CLK_I(CLK_I), .RST_I(RST_I), .X16_I(X16_I), .BL_I(BL_I),
    .LNK(lnk));
  lpddr_link_props i_lpddr_link_props (.CLK_I(CLK_I), .RST_I(RST_I), .ck(lnk.ck),
    .cmd(lnk.cmd), .dq_c_oe(lnk.dq_c_oe), .dqs_c(lnk.dqs_c), .dqs_c_oe(lnk.dqs_c_oe),
    .dq_d_oe(lnk.dq_d_oe), .dqs_d(lnk.dqs_d), .dqs_d_oe(lnk.dqs_d_oe), .dqs(lnk.dqs));

  // write data advance on each take pulse; read elements gathered for later compare
  always @(posedge CLK_I)
  begin
    if (WD_TAKE_O === 1'b1)
      wd_idx <= wd_idx + 1;
    if (RD_VALID_O === 1'b1)
      rq.push_back(RD_DATA_O);
  end

  task automatic err(input string s);
    $display("unexpected at %0t ns: %s", $time, s);
    fail_count++;
  endtask : err

  // holds the request until ready is seen before a rising edge, so it is taken there
  task automatic req(input cmd_e c, input logic [1:0] ba, input logic [3:0] a,
                     input logic ap, output logic ok);
    ok = 1'b0;
    @(posedge CLK_I);
    REQ_VALID_I <= 1'b1;
    REQ_CMD_I <= c;
    REQ_BA_I <= ba;
    REQ_ADDR_I <= a;
    REQ_AP_I <= ap;
    for (int k = 0; k < 160 && ok !== 1'b1; k++)
    begin
      @(negedge CLK_I);
      if (REQ_READY_O === 1'b1)
        ok = 1'b1;
    end
    @(posedge CLK_I);
    REQ_VALID_I <= 1'b0;
  endtask : req

  task automatic go(input cmd_e c, input logic [1:0] ba, input logic [3:0] a, input logic ap);
    logic ok;
    req(c, ba, a, ap, ok);
    samples_checked++;
    if (ok !== 1'b1)
    begin
      err("legal request never taken");
      print_verdict();
    end
  endtask : go

  task automatic refuse(input cmd_e c, input logic [1:0] ba, input logic [3:0] a);
    logic ok;
    req(c, ba, a, 1'b0, ok);
    samples_checked++;
    if (ok !== 1'b0)
      err("request to a closed bank was taken");
  endtask : refuse

  // masks only on odd elements; image updated only for unmasked lanes
  task automatic wr(input logic [1:0] ba, input logic [3:0] col, input logic ap, input int n,
                    input logic [31:0] base, input logic [3:0] m);
    logic [3:0] cc;
    for (int i = 0; i < n; i++)
    begin
      cc = 4'((col & ~(n - 1)) | ((col + i) & (n - 1)));
      wdat[wp] = base + 32'(i) * 32'h01010101;
      wmsk[wp] = i[0] ? m : 4'h0;
      for (int b = 0; b < 4; b++)
        if (!wmsk[wp][b])
          mexp[{ba, cc}][8*b +: 8] = wdat[wp][8*b +: 8];
      wp++;
    end
    go(CMD_WR, ba, col, ap);
  endtask : wr

  task automatic rd(input logic [1:0] ba, input logic [3:0] col, input logic ap, input int n);
    logic [3:0] cc;
    for (int i = 0; i < n; i++)
    begin
      cc = 4'((col & ~(blen - 1)) | ((col + i) & (blen - 1)));
      eq.push_back(X16_I ? (mexp[{ba, cc}] & 32'h0000FFFF) : mexp[{ba, cc}]);
    end
    go(CMD_RD, ba, col, ap);
  endtask : rd

  task automatic flush();
    int q;
    q = 0;
    for (int k = 0; k < 600 && q < 48; k++)
    begin
      @(posedge CLK_I);
      q = (RD_VALID_O === 1'b1) ? 0 : q + 1;
    end
    samples_checked++;
    if (q < 48)
    begin
      err("read data never went quiet");
      print_verdict();
    end
    samples_checked++;
    if (rq.size() != eq.size())
      err("wrong number of read elements");
    else
      foreach (eq[i])
      begin
        samples_checked++;
        if (rq[i] !== eq[i])
          err("read element differs from written data");
      end
    rq.delete();
    eq.delete();
  endtask : flush

  task automatic set_bl(input bl_t c);
    @(posedge CLK_I);
    BL_I <= c;
    blen = 2 << c;
  endtask : set_bl

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict

  initial
  begin
    repeat (20) @(posedge CLK_I);
    RST_I <= 1'b0;
    go(CMD_ACT, 2'h0, 4'h1, 1'b0);
    go(CMD_ACT, 2'h1, 4'h2, 1'b0);
    wr(2'h0, 4'h0, 1'b0, 16, 32'h10203040, 4'h0);
    rd(2'h0, 4'h5, 1'b0, 16);
    flush();
    set_bl(2'h1);
    wr(2'h0, 4'h0, 1'b0, 4, 32'hA0B0C0D0, 4'h0);
    go(CMD_NOP, 2'h0, 4'h0, 1'b0);
    wr(2'h0, 4'h6, 1'b0, 4, 32'h55667788, 4'h5);
    rd(2'h0, 4'h0, 1'b0, 4);
    go(CMD_NOP, 2'h0, 4'h0, 1'b0);
    rd(2'h0, 4'h6, 1'b0, 4);
    flush();
    rd(2'h0, 4'h0, 1'b0, 2);
    go(CMD_BST, 2'h0, 4'h0, 1'b0);
    flush();
    rd(2'h0, 4'h8, 1'b0, 4);
    flush();
    rd(2'h0, 4'h0, 1'b0, 4);
    go(CMD_NOP, 2'h0, 4'h0, 1'b0);
    go(CMD_PRE, 2'h0, 4'h0, 1'b0);
    flush();
    refuse(CMD_RD, 2'h0, 4'h0);
    go(CMD_ACT, 2'h0, 4'h1, 1'b0);
    rd(2'h0, 4'h4, 1'b1, 4);
    flush();
    refuse(CMD_RD, 2'h0, 4'h4);
    go(CMD_ACT, 2'h0, 4'h1, 1'b0);
    wr(2'h1, 4'h0, 1'b1, 4, 32'h31415926, 4'h0);
    flush();
    refuse(CMD_RD, 2'h1, 4'h0);
    go(CMD_ACT, 2'h1, 4'h2, 1'b0);
    rd(2'h1, 4'h0, 1'b0, 4);
    flush();
    set_bl(2'h2);
    rd(2'h0, 4'h0, 1'b0, 2);
    rd(2'h0, 4'h8, 1'b0, 8);
    flush();
    set_bl(2'h0);
    rd(2'h0, 4'h0, 1'b0, 2);
    rd(2'h0, 4'h3, 1'b0, 2);
    flush();
    set_bl(2'h1);
    rd(2'h0, 4'h0, 1'b0, 2);
    wr(2'h0, 4'h8, 1'b0, 4, 32'h0F1E2D3C, 4'h0);
    rd(2'h0, 4'h8, 1'b0, 4);
    flush();
    X16_I <= 1'b1;
    wr(2'h1, 4'h4, 1'b0, 4, 32'hC3C3A5A5, 4'h0);
    rd(2'h1, 4'h4, 1'b0, 4);
    flush();
    print_verdict();
  end
endmodule : tb
